//--- hdl/ubl_baud_gen.sv
// Baud divisor counter giving the sixteen-times oversampling tick
`timescale 1ns/1ns
module ubl_baud_gen (
  input wire logic core_clk,
  input wire logic rst_b,
  ubl_baud_if.gen bif
);
  import ubl_pkg::*;

  logic [15:0] cnt_q;
  logic tick_q;
  logic [16:0] gap_q;
  logic seen_q;

  // Expire after divisor plus one cycles; >= guards a shrunk divisor
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (!bif.run) begin
      tick_q <= 1'b0; // Frozen, count held for resume
    end else if (cnt_q >= bif.divisor) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end
  assign bif.tick = tick_q;

  // Helper: cycles since the last tick while running steadily
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_q <= 17'h00000;
      seen_q <= 1'b0;
    end else if (!bif.run || $changed(bif.divisor)) begin
      gap_q <= 17'h00000;
      seen_q <= 1'b0;
    end else if (tick_q) begin
      gap_q <= 17'h00001;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 17'h00001;
    end
  end

  property p_tick_period;
    @(posedge core_clk) disable iff (!rst_b)
    (tick_q && seen_q && bif.run && $stable(bif.divisor))
      |-> gap_q == {1'b0, bif.divisor} + 17'h00001;
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("baud tick spacing differs from divisor plus one");

  property p_no_tick_stopped;
    @(posedge core_clk) disable iff (!rst_b)
    !bif.run |=> !tick_q;
  endproperty
  a_no_tick_stopped: assert property (p_no_tick_stopped)
    else $error("baud tick seen while the generator is stopped");
endmodule : ubl_baud_gen

//--- hdl/ubl_baud_if.sv
// Carrier between the port core and its baud tick generator
`timescale 1ns/1ns
interface ubl_baud_if;
  logic [15:0] divisor;
  logic run;
  logic tick;
  modport gen (input divisor, input run, output tick);
  modport user (output divisor, output run, input tick);
endinterface : ubl_baud_if

//--- hdl/ubl_pkg.sv
// Shared constants and types for the serial port baud, loopback and power block
package ubl_pkg;
  // Register indices; the bus byte address is four times the index
  localparam logic [9:0] P1_MODE_IDX = 10'h20C;
  localparam logic [9:0] P1_STA_IDX = 10'h20E;
  localparam logic [9:0] P1_TXD_IDX = 10'h210;
  localparam logic [9:0] P1_RXD_IDX = 10'h212;
  localparam logic [9:0] P1_BRG_IDX = 10'h214;
  localparam logic [9:0] P2_MODE_IDX = 10'h216;
  localparam logic [9:0] P2_STA_IDX = 10'h218;
  localparam logic [9:0] P2_TXD_IDX = 10'h21A;
  localparam logic [9:0] P2_RXD_IDX = 10'h21C;
  localparam logic [9:0] P2_BRG_IDX = 10'h21E;
  // Interrupt status and mask registers
  localparam logic [9:0] P1_ISTA_IDX = 10'h220;
  localparam logic [9:0] P1_IMSK_IDX = 10'h222;
  localparam logic [9:0] P2_ISTA_IDX = 10'h224;
  localparam logic [9:0] P2_IMSK_IDX = 10'h226;

  // Mode register fields
  localparam int MODE_ON = 15;
  localparam int MODE_HALT = 13;
  localparam int MODE_WAKE = 7;
  localparam int MODE_LOOP = 6;
  localparam int MODE_CAPT = 5;
  localparam int MODE_STOP = 0;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] MODE_WMASK = 16'hA0E7;

  // Status register fields
  localparam int STA_TXSEL = 15;
  localparam int STA_OERR = 1;
  localparam logic [15:0] STA_RST = 16'h0110;
  localparam logic [15:0] STA_WMASK = 16'h80C0;

  // Interrupt status bits
  localparam int IRQ_W = 3;
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_WAKE = 2;

  // Oversampling: sixteen ticks a bit, sample at the middle
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_HALF = 4'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef enum logic [3:0] {
    SER_IDLE = 4'h1,
    SER_START = 4'h2,
    SER_DATA = 4'h4,
    SER_STOP = 4'h8
  } ubl_ser_t;
endpackage : ubl_pkg

//--- hdl/ubl_port.sv
// One serial port: registers, baud, loopback, capture link and power modes
`timescale 1ns/1ns
module ubl_port #(
  parameter bit PORT2 = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic capture_link_out,
  input wire logic cpu_sleep,
  input wire logic cpu_idle,
  output logic irq_o
);
  import ubl_pkg::*;

  localparam logic [9:0] I_MODE = PORT2 ? P2_MODE_IDX : P1_MODE_IDX;
  localparam logic [9:0] I_STA = PORT2 ? P2_STA_IDX : P1_STA_IDX;
  localparam logic [9:0] I_TXD = PORT2 ? P2_TXD_IDX : P1_TXD_IDX;
  localparam logic [9:0] I_RXD = PORT2 ? P2_RXD_IDX : P1_RXD_IDX;
  localparam logic [9:0] I_BRG = PORT2 ? P2_BRG_IDX : P1_BRG_IDX;
  localparam logic [9:0] I_ISTA = PORT2 ? P2_ISTA_IDX : P1_ISTA_IDX;
  localparam logic [9:0] I_IMSK = PORT2 ? P2_IMSK_IDX : P1_IMSK_IDX;

  // Address match on the word index
  function automatic logic hit(input logic [11:0] adr, input logic [9:0] idx);
    hit = (adr[11:2] == idx);
  endfunction : hit

  // Byte-lane merge of a 16-bit register under a writable mask
  function automatic logic [15:0] merge(input logic [15:0] old,
      input logic [31:0] dat, input logic [3:0] sel, input logic [15:0] msk);
    logic [15:0] nw;
    nw = old;
    if (sel[0]) nw[7:0] = dat[7:0];
    if (sel[1]) nw[15:8] = dat[15:8];
    merge = (nw & msk) | (old & ~msk);
  endfunction : merge

  logic [15:0] mode_q;
  logic [15:0] brg_q;
  logic [15:0] sta_ctl_q;
  logic oerr_q;
  logic avail_q;
  logic [7:0] rxbuf_q;
  logic [IRQ_W-1:0] ista_q;
  logic [IRQ_W-1:0] imsk_q;
  ubl_ser_t tx_st_q;
  ubl_ser_t rx_st_q;
  logic [3:0] tx_cnt_q;
  logic [3:0] rx_cnt_q;
  logic [2:0] tx_bit_q;
  logic [2:0] rx_bit_q;
  logic [7:0] tx_sh_q;
  logic [7:0] rx_sh_q;
  logic tx_stop2_q;
  logic tx_done_q;
  logic rx_done_q;
  logic [15:0] rd_d;
  logic [15:0] sta_rd;
  logic acc;
  logic wr;
  logic rd;
  logic port_on;
  logic abort;
  logic tx_load;
  logic tx_end;
  logic rx_line;
  logic rx_fall;
  logic wake_ev;

  ubl_baud_if bif ();

  // Bus access is taken on the first cycle of a request only
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = acc & wb_we_i;
  assign rd = acc & ~wb_we_i;
  assign port_on = mode_q[MODE_ON];
  // Sleep, or the port switched off, kills any frame in flight
  assign abort = cpu_sleep | ~port_on;

  // Tick runs only while enabled, awake and not halted in idle
  assign bif.divisor = brg_q;
  assign bif.run = port_on & ~cpu_sleep
    & ~(cpu_idle & mode_q[MODE_HALT]);

  ubl_baud_gen u_baud (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .bif(bif)
  );

  ubl_rx_front u_front (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .serial_in_pin(serial_in_pin),
    .loopback_select(mode_q[MODE_LOOP]),
    .tx_line(serial_out_pin),
    .rx_line(rx_line),
    .rx_fall(rx_fall)
  );

  // Wishbone slave: one wait state, unmapped reads return zero
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= rd ? {16'h0000, rd_d} : 32'h00000000;
    end
  end

  // Status view; transmit full and shift-empty track the single shifter
  assign sta_rd = {sta_ctl_q[15], 5'h00, tx_st_q != SER_IDLE,
    tx_st_q == SER_IDLE, sta_ctl_q[7:6], 1'b0, rx_st_q == SER_IDLE,
    2'h0, oerr_q, avail_q};

  // Read data decode
  always_comb begin
    rd_d = 16'h0000;
    if (hit(wb_adr_i, I_MODE)) begin
      rd_d = mode_q;
    end else if (hit(wb_adr_i, I_STA)) begin
      rd_d = sta_rd;
    end else if (hit(wb_adr_i, I_RXD)) begin
      rd_d = {8'h00, rxbuf_q};
    end else if (hit(wb_adr_i, I_BRG)) begin
      rd_d = brg_q;
    end else if (hit(wb_adr_i, I_ISTA)) begin
      rd_d = {13'h0000, ista_q};
    end else if (hit(wb_adr_i, I_IMSK)) begin
      rd_d = {13'h0000, imsk_q};
    end
  end

  // Configuration registers; sleep never touches them
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= MODE_RST;
      brg_q <= 16'h0000;
      sta_ctl_q <= 16'h0000;
      imsk_q <= '0;
    end else if (wr) begin
      if (hit(wb_adr_i, I_MODE)) begin
        mode_q <= merge(mode_q, wb_dat_i, wb_sel_i, MODE_WMASK);
      end else if (hit(wb_adr_i, I_STA)) begin
        sta_ctl_q <= merge(sta_ctl_q, wb_dat_i, wb_sel_i, STA_WMASK);
      end else if (hit(wb_adr_i, I_BRG)) begin
        brg_q <= merge(brg_q, wb_dat_i, wb_sel_i, 16'hFFFF);
      end else if (hit(wb_adr_i, I_IMSK) && wb_sel_i[0]) begin
        imsk_q <= wb_dat_i[IRQ_W-1:0];
      end
    end
  end

  // A write lands in the shifter only when it is empty
  assign tx_load = wr & hit(wb_adr_i, I_TXD) & wb_sel_i[0]
    & (tx_st_q == SER_IDLE) & ~abort;
  assign tx_end = bif.tick & (tx_cnt_q == OVS_LAST);

  // Transmitter: start, eight data bits LSB first, one or two stops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_st_q <= SER_IDLE;
      serial_out_pin <= 1'b1;
      tx_cnt_q <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_sh_q <= 8'h00;
      tx_stop2_q <= 1'b0;
      tx_done_q <= 1'b0;
    end else if (abort) begin
      tx_st_q <= SER_IDLE;
      serial_out_pin <= 1'b1;
      tx_cnt_q <= 4'h0;
      tx_done_q <= 1'b0;
    end else begin
      tx_done_q <= 1'b0;
      if (bif.tick) tx_cnt_q <= tx_cnt_q + 4'h1;
      case (tx_st_q)
        SER_IDLE: begin
          if (tx_load) begin
            tx_sh_q <= wb_dat_i[7:0];
            tx_st_q <= SER_START;
            serial_out_pin <= 1'b0; // Pin driven also in loopback
            tx_cnt_q <= 4'h0;
          end
        end
        SER_START: begin
          if (tx_end) begin
            tx_st_q <= SER_DATA;
            serial_out_pin <= tx_sh_q[0];
            tx_bit_q <= 3'h0;
          end
        end
        SER_DATA: begin
          if (tx_end) begin
            if (tx_bit_q == BIT_LAST) begin
              tx_st_q <= SER_STOP;
              serial_out_pin <= 1'b1;
              tx_stop2_q <= mode_q[MODE_STOP];
            end else begin
              serial_out_pin <= tx_sh_q[1];
              tx_sh_q <= {1'b0, tx_sh_q[7:1]};
              tx_bit_q <= tx_bit_q + 3'h1;
            end
          end
        end
        SER_STOP: begin
          if (tx_end) begin
            if (tx_stop2_q) begin
              tx_stop2_q <= 1'b0;
            end else begin
              tx_st_q <= SER_IDLE;
              tx_done_q <= 1'b1;
            end
          end
        end
        default: tx_st_q <= SER_IDLE;
      endcase
    end
  end

  // Receiver: qualify start at mid-bit, then sample every sixteen ticks
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_st_q <= SER_IDLE;
      rx_cnt_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_done_q <= 1'b0;
    end else if (abort) begin
      rx_st_q <= SER_IDLE;
      rx_cnt_q <= 4'h0;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (bif.tick) begin
        rx_cnt_q <= rx_cnt_q + 4'h1;
        case (rx_st_q)
          SER_IDLE: begin
            if (!rx_line) begin
              rx_st_q <= SER_START;
              rx_cnt_q <= 4'h0;
            end
          end
          SER_START: begin
            if (rx_cnt_q == OVS_HALF) begin
              rx_cnt_q <= 4'h0;
              rx_bit_q <= 3'h0;
              rx_st_q <= rx_line ? SER_IDLE : SER_DATA; // Glitch filter
            end
          end
          SER_DATA: begin
            if (rx_cnt_q == OVS_LAST) begin
              rx_sh_q <= {rx_line, rx_sh_q[7:1]};
              rx_bit_q <= rx_bit_q + 3'h1;
              if (rx_bit_q == BIT_LAST) rx_st_q <= SER_STOP;
            end
          end
          SER_STOP: begin
            if (rx_cnt_q == OVS_LAST) begin
              rx_st_q <= SER_IDLE;
              rx_done_q <= 1'b1;
            end
          end
          default: rx_st_q <= SER_IDLE;
        endcase
      end
    end
  end

  // Holding register; a read empties it, a new character wins the race
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxbuf_q <= 8'h00;
      avail_q <= 1'b0;
      oerr_q <= 1'b0;
    end else begin
      if (rx_done_q) begin
        rxbuf_q <= rx_sh_q;
        avail_q <= 1'b1;
      end else if (rd && hit(wb_adr_i, I_RXD)) begin
        avail_q <= 1'b0;
      end
      if (rx_done_q && avail_q) begin
        oerr_q <= 1'b1; // New character overwrites the old one, overrun flagged
      end else if (wr && hit(wb_adr_i, I_STA) && wb_sel_i[0]
          && !wb_dat_i[STA_OERR]) begin
        oerr_q <= 1'b0;
      end
    end
  end

  // Wake needs the enable but not the rx interrupt selection
  assign wake_ev = cpu_sleep & port_on & mode_q[MODE_WAKE]
    & rx_fall;

  // Sticky events, write one to clear; a same-cycle set is kept
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ista_q <= '0;
    end else begin
      for (int i = 0; i < IRQ_W; i++) begin
        if ((i == IRQ_RX && (rx_done_q || wake_ev))
            || (i == IRQ_TX && tx_done_q)
            || (i == IRQ_WAKE && wake_ev)) begin
          ista_q[i] <= 1'b1;
        end else if (wr && hit(wb_adr_i, I_ISTA) && wb_sel_i[0]
            && wb_dat_i[i]) begin
          ista_q[i] <= 1'b0;
        end
      end
    end
  end

  // Registered outputs: interrupt level and capture channel feed
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_o <= 1'b0;
      capture_link_out <= 1'b1;
    end else begin
      irq_o <= |(ista_q & imsk_q);
      capture_link_out <= mode_q[MODE_CAPT] ? rx_line : 1'b1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_loop_route;
    mode_q[MODE_LOOP] |-> rx_line == serial_out_pin;
  endproperty
  a_loop_route: assert property (p_loop_route)
    else $error("loopback receive line does not follow transmit");

  property p_loop_deaf;
    (mode_q[MODE_LOOP] && serial_out_pin && rx_st_q == SER_IDLE && !abort)
      |=> rx_st_q == SER_IDLE;
  endproperty
  a_loop_deaf: assert property (p_loop_deaf)
    else $error("receiver started from the pin during loopback");

  property p_sleep_line;
    cpu_sleep |=> serial_out_pin && tx_st_q == SER_IDLE;
  endproperty
  a_sleep_line: assert property (p_sleep_line)
    else $error("transmit not aborted high in sleep");

  property p_sleep_rx;
    cpu_sleep |=> rx_st_q == SER_IDLE && !rx_done_q;
  endproperty
  a_sleep_rx: assert property (p_sleep_rx)
    else $error("reception not abandoned in sleep");

  property p_sleep_keep;
    (cpu_sleep && !wr && !rx_done_q) |=> $stable(mode_q) && $stable(brg_q)
      && $stable(rxbuf_q);
  endproperty
  a_sleep_keep: assert property (p_sleep_keep)
    else $error("register changed across sleep");

  property p_wake_irq;
    (wake_ev && imsk_q[IRQ_RX] && !wr)
      |=> ista_q[IRQ_RX] && ista_q[IRQ_WAKE] ##1 irq_o;
  endproperty
  a_wake_irq: assert property (p_wake_irq)
    else $error("wake edge did not raise the receive interrupt");

  property p_wake_needs_on;
    !port_on |=> !$rose(ista_q[IRQ_WAKE]);
  endproperty
  a_wake_needs_on: assert property (p_wake_needs_on)
    else $error("wake interrupt raised with the port disabled");

  property p_ack_once;
    acc |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("bus answer not a single cycle after the request");
endmodule : ubl_port

//--- hdl/ubl_rx_front.sv
// Serial input synchroniser, loopback select and falling edge detect
`timescale 1ns/1ns
module ubl_rx_front (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic serial_in_pin,
  input wire logic loopback_select,
  input wire logic tx_line,
  output logic rx_line,
  output logic rx_fall
);
  logic s1_q;
  logic s2_q;
  logic prev_q;

  // Two flops for the asynchronous pin; idle line is high
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else begin
      s1_q <= serial_in_pin;
      s2_q <= s1_q;
    end
  end

  // In loopback the pin is cut off and the transmit line feeds receive
  assign rx_line = loopback_select ? tx_line : s2_q;

  // Edge memory follows whichever line feeds the receiver
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= rx_line;
    end
  end
  assign rx_fall = prev_q & ~rx_line;
endmodule : ubl_rx_front

//--- tb/tb.sv
// Self-checking bench for one serial port behind its register bus
`timescale 1ns/1ns
module tb;
  import ubl_pkg::*;
  localparam logic [11:0] A_MODE = {P1_MODE_IDX, 2'h0};
  localparam logic [11:0] A_STA = {P1_STA_IDX, 2'h0};
  localparam logic [11:0] A_TXD = {P1_TXD_IDX, 2'h0};
  localparam logic [11:0] A_RXD = {P1_RXD_IDX, 2'h0};
  localparam logic [11:0] A_BRG = {P1_BRG_IDX, 2'h0};
  localparam logic [11:0] A_IST = {P1_ISTA_IDX, 2'h0};
  localparam logic [11:0] A_MSK = {P1_IMSK_IDX, 2'h0};
  logic core_clk, rst_b, cyc, stb, we, sleep, idle;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, rdat;
  logic ack, pin_in, pin_out, cap, irq, v;
  logic [15:0] q;
  int n_fail = 0;
  int compares = 0;
  int n, k;

  ubl_port #(.PORT2(1'b0)) dut_u (
    .core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .serial_in_pin(pin_in),
    .serial_out_pin(pin_out), .capture_link_out(cap),
    .cpu_sleep(sleep), .cpu_idle(idle), .irq_o(irq)
  );
  ubl_remote rem (.core_clk(core_clk), .line_in(pin_out), .line_out(pin_in));

  // 25 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      n_fail++;
    end
  endtask : chk

  // Classic cycle; held until ack is sampled high, then released
  task automatic wb(input logic [11:0] a, input logic w,
                    input logic [15:0] d, input logic [3:0] s);
    int t;
    t = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= {16'h0000, d};
    do begin
      @(posedge core_clk);
      t++;
    end while (ack !== 1'b1 && t < 64);
    q = rdat[15:0];
    chk("bus ack", {15'h0000, ack}, 16'h0001);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    wb(a, 1'b1, d, 4'h3);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [15:0] e,
                    input string nm);
    wb(a, 1'b0, 16'h0000, 4'h3);
    chk(nm, q, e);
  endtask : rd

  // Processor power state; both levels move at the same edge
  task automatic pwr(input logic s, input logic i);
    sleep <= s;
    idle <= i;
  endtask : pwr

  // Bounded waits for the interrupt and for a frame at the remote end
  task automatic wirq();
    int t;
    t = 0;
    while (irq !== 1'b1 && t < 1000) begin
      @(posedge core_clk);
      t++;
    end
    chk("irq", {15'h0000, irq}, 16'h0001);
  endtask : wirq

  task automatic wrem(input int k0, input logic [7:0] e);
    int t;
    t = 0;
    while (rem.ngot == k0 && t < 1000) begin
      @(posedge core_clk);
      t++;
    end
    chk("remote count", 16'(rem.ngot - k0), 16'h0001);
    chk("remote byte", {8'h00, rem.got}, {8'h00, e});
  endtask : wrem

  task automatic final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // A hang counts as a mismatch
  initial begin
    #2000000;
    n_fail++;
    final_report();
  end

  initial begin
    rst_b = 1'b0;
    {cyc, stb, we, sleep, idle} = 5'h00;
    adr = 12'h000;
    sel = 4'h0;
    dat = 32'h00000000;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(A_MODE, 16'h0000, "mode reset");
    rd(A_STA, 16'h0110, "status reset");
    rd(A_BRG, 16'h0000, "divisor reset");
    rd(A_RXD, 16'h0000, "rx data reset");
    rd(12'hFFC, 16'h0000, "unmapped");
    wr(A_BRG, 16'hFFFF);
    rd(A_BRG, 16'hFFFF, "divisor max");
    wb(A_BRG, 1'b1, 16'h1234, 4'h1);
    rd(A_BRG, 16'hFF34, "divisor low lane");
    wr(A_MODE, 16'hFFFF);
    rd(A_MODE, 16'hA0E7, "mode fields");
    wr(A_BRG, 16'h0001);
    // Capture link, with the port off so nothing is received
    wr(A_MODE, 16'h0000);
    rem.hold(1'b0);
    repeat (6) @(posedge core_clk);
    chk("capture off", {15'h0000, cap}, 16'h0001);
    wr(A_MODE, 16'h0020);
    repeat (6) @(posedge core_clk);
    chk("capture low", {15'h0000, cap}, 16'h0000);
    rem.hold(1'b1);
    repeat (6) @(posedge core_clk);
    chk("capture high", {15'h0000, cap}, 16'h0001);
    // Transmit; the low data bit 1 gives the bit time, free of tick phase
    wr(A_MSK, 16'h0007);
    wr(A_MODE, 16'h8000);
    k = rem.ngot;
    wr(A_TXD, 16'h00A5);
    n = 0;
    while (pin_out !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    n = 0;
    while (pin_out === 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    n = 0;
    while (pin_out === 1'b0 && n < 1000) begin
      @(posedge core_clk);
      n++;
    end
    chk("bit time", 16'(n), 16'h0020);
    wrem(k, 8'hA5);
    wirq();
    rd(A_IST, 16'h0002, "tx done");
    wr(A_IST, 16'h0002);
    repeat (3) @(posedge core_clk);
    chk("irq cleared", {15'h0000, irq}, 16'h0000);
    // Receive
    rem.send(8'h3C);
    repeat (40) @(posedge core_clk);
    rd(A_RXD, 16'h003C, "rx byte");
    rd(A_IST, 16'h0001, "rx event");
    wr(A_IST, 16'h0007);
    // Loopback with the outside pin held low
    wr(A_MODE, 16'h8040);
    rem.hold(1'b0);
    k = rem.ngot;
    wr(A_TXD, 16'h005A);
    wrem(k, 8'h5A);
    repeat (40) @(posedge core_clk);
    rd(A_RXD, 16'h005A, "loop byte");
    rem.hold(1'b1);
    wr(A_MODE, 16'h8001);
    wr(A_IST, 16'h0007);
    // Idle with halt clear keeps running, two stop bits this time
    pwr(1'b0, 1'b1);
    k = rem.ngot;
    wr(A_TXD, 16'h00F0);
    wrem(k, 8'hF0);
    pwr(1'b0, 1'b0);
    wirq();
    wr(A_IST, 16'h0007);
    // Idle with halt set freezes the line, then resumes
    wr(A_MODE, 16'hA000);
    wr(A_TXD, 16'h000F);
    repeat (48) @(posedge core_clk);
    pwr(1'b0, 1'b1);
    repeat (3) @(posedge core_clk);
    v = pin_out;
    n = 0;
    repeat (200) begin
      @(posedge core_clk);
      if (pin_out !== v) n++;
    end
    chk("frozen", 16'(n), 16'h0000);
    pwr(1'b0, 1'b0);
    wirq();
    wr(A_IST, 16'h0007);
    // Sleep in mid-frame aborts and holds the line high
    wr(A_MODE, 16'h8000);
    wr(A_TXD, 16'h0000);
    repeat (100) @(posedge core_clk);
    pwr(1'b1, 1'b0);
    repeat (3) @(posedge core_clk);
    chk("sleep line", {15'h0000, pin_out}, 16'h0001);
    pwr(1'b0, 1'b0);
    rd(A_MODE, 16'h8000, "mode kept");
    rd(A_BRG, 16'h0001, "divisor kept");
    rd(A_STA, 16'h0110, "status kept");
    rd(A_RXD, 16'h005A, "data kept");
    repeat (400) @(posedge core_clk);
    wr(A_IST, 16'h0007);
    // Wake on falling input, rx select at its strictest setting
    wr(A_STA, 16'h00C0);
    wr(A_MODE, 16'h8080);
    pwr(1'b1, 1'b0);
    rem.hold(1'b0);
    wirq();
    rem.hold(1'b1);
    pwr(1'b0, 1'b0);
    rd(A_IST, 16'h0005, "wake event");
    wr(A_IST, 16'h0007);
    // No wake while the port is off
    wr(A_MODE, 16'h0080);
    pwr(1'b1, 1'b0);
    rem.hold(1'b0);
    repeat (20) @(posedge core_clk);
    chk("no wake", {15'h0000, irq}, 16'h0000);
    rem.hold(1'b1);
    pwr(1'b0, 1'b0);
    rd(A_IST, 16'h0000, "no wake event");
    final_report();
  end
endmodule : tb

//--- tb/ubl_remote.sv
// Remote serial device model: frame sender and frame receiver
`timescale 1ns/1ns
module ubl_remote (
  input wire logic core_clk,
  input wire logic line_in,
  output logic line_out
);
  int bitc = 32;
  logic [7:0] got;
  int ngot = 0;

  // Idle line rests high, as an unloaded serial line does
  initial begin
    line_out = 1'b1;
  end

  // Drive a steady level, a long low stands for a break
  task automatic hold(input logic v);
    @(posedge core_clk);
    line_out <= v;
  endtask : hold

  // One frame, start low, data LSB first, one stop bit
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk);
      line_out <= f[i];
      repeat (bitc - 1) @(posedge core_clk);
    end
  endtask : send

  // Mid-bit sampling; a low shorter than half a bit is not a start
  initial begin
    forever begin
      @(negedge line_in);
      repeat (bitc / 2) @(posedge core_clk);
      if (line_in === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (bitc) @(posedge core_clk);
          got[i] = line_in;
        end
        repeat (bitc) @(posedge core_clk);
        ngot++;
      end
    end
  end
endmodule : ubl_remote
